//--- logic/dao_pkg.sv
`default_nettype none
package dao_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_AUDIO_CTRL = 8'h2b;
    localparam logic [7:0] ADDR_MCLK_SEL   = 8'h3a;

    // Audio control fields
    localparam int         CTRL_PLL_EN_BIT    = 0;
    localparam int         CTRL_BLANK_SRC_BIT = 1;
    localparam int         CTRL_SEC_EN_BIT    = 2;
    localparam logic [7:0] CTRL_RESET         = 8'h01;

    // Master clock select fields
    localparam int         MSEL_OVR_BIT  = 7;
    localparam int         MSEL_CODE_LSB = 4;
    localparam int         MSEL_LOCK_BIT = 3;
    localparam logic [2:0] MSEL_CODE_RST = 3'h0;

    // Ratio as a left shift of the bit clock: x1, x2, x4
    localparam logic [1:0] SHIFT_DEFAULT = 2'h1;
    localparam logic [1:0] SHIFT_MAX     = 2'h2;

    // Timing, reference clock 125 MHz
    localparam int REF_PERIOD_NS = 8;
    localparam int JITTER_NS     = 2;
    localparam int LOCK_TOL_CYC  = (JITTER_NS / REF_PERIOD_NS > 0) ? JITTER_NS / REF_PERIOD_NS : 1;
    // Bit clock period boundaries between code bands
    localparam int BAND1_NS  = 560;
    localparam int BAND2_NS  = 280;
    localparam int BAND3_NS  = 135;
    localparam int BAND1_CYC = BAND1_NS / REF_PERIOD_NS;
    localparam int BAND2_CYC = BAND2_NS / REF_PERIOD_NS;
    localparam int BAND3_CYC = BAND3_NS / REF_PERIOD_NS;
    localparam int STRAP_WAIT_CYC = 6;
endpackage : dao_pkg
`default_nettype wire

//--- logic/dao_mclk_gen.sv
`timescale 1ns/1ps
`default_nettype none
module dao_mclk_gen #(
    parameter int PERIOD_W = 10
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                bitRise,
    input  wire logic                pllEnable,
    input  wire logic [1:0]          ratioShift,
    output logic                     bclkRegen,
    output logic                     mclk,
    output logic                     locked,
    output logic [PERIOD_W-1:0]      period
);
    logic [PERIOD_W-1:0] measCnt;
    logic [PERIOD_W-1:0] measNow;
    logic [PERIOD_W-1:0] diff;
    logic [PERIOD_W+1:0] avgSum;
    logic [PERIOD_W-1:0] avgNew;
    logic [PERIOD_W-1:0] next_period;
    logic [PERIOD_W-1:0] phase;
    logic [PERIOD_W-1:0] next_phase;
    logic [PERIOD_W-1:0] mCnt;
    logic [PERIOD_W-1:0] mHalf;
    logic [PERIOD_W-1:0] next_mHalf;
    logic                periodOk;
    logic                bclkStart;

    if (PERIOD_W < 8) begin : g_bad_width
        $error("dao_mclk_gen: PERIOD_W too small");
    end

    assign measNow   = (measCnt == '1) ? measCnt : measCnt + 1'b1;
    assign diff      = (measNow > period) ? measNow - period : period - measNow;
    assign avgSum    = ({2'b00, period} << 1) + {2'b00, period} + {2'b00, measNow};
    assign avgNew    = avgSum[PERIOD_W+1:2];
    assign periodOk  = period >= PERIOD_W'(2);

    // Truncated average stalls short of a longer period; last cycles are stepped
    always_comb begin
        if (period == '0) begin
            next_period = measNow;
        end else if (avgNew != period) begin
            next_period = avgNew;
        end else if (measNow > period) begin
            next_period = period + 1'b1;
        end else if (measNow < period) begin
            next_period = period - 1'b1;
        end else begin
            next_period = period;
        end
    end
    assign bclkStart = periodOk && (next_phase == '0);

    always_comb begin
        if (!periodOk || (bitRise && !locked)) begin
            next_phase = '0;
        end else if (phase == period - 1'b1) begin
            next_phase = '0;
        end else begin
            next_phase = phase + 1'b1;
        end
        case (ratioShift)
            2'h0:    next_mHalf = period >> 1;
            2'h1:    next_mHalf = period >> 2;
            default: next_mHalf = period >> 3;
        endcase
        if (next_mHalf == '0) begin
            next_mHalf = PERIOD_W'(1);
        end
    end

    // Averaged period filters edge jitter out of the regenerated clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            measCnt <= '0;
            period  <= '0;
            locked  <= 1'b0;
        end else if (bitRise) begin
            measCnt <= '0;
            period  <= next_period;
            locked  <= (period != '0) && (diff <= PERIOD_W'(dao_pkg::LOCK_TOL_CYC));
        end else if (measCnt != '1) begin
            measCnt <= measCnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase     <= '0;
            bclkRegen <= 1'b0;
        end else begin
            phase     <= next_phase;
            bclkRegen <= periodOk && (next_phase < (period >> 1));
        end
    end

    // Ratio only latched at a bit clock rise, so no runt pulse on a change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mCnt  <= '0;
            mHalf <= PERIOD_W'(1);
            mclk  <= 1'b0;
        end else if (bclkStart) begin
            mCnt  <= '0;
            mHalf <= next_mHalf;
            mclk  <= pllEnable;
        end else if (mCnt == mHalf - 1'b1) begin
            mCnt <= '0;
            mclk <= pllEnable & ~mclk;
        end else begin
            mCnt <= mCnt + 1'b1;
            mclk <= pllEnable & mclk;
        end
    end

    sequence s_bclk_start;
        bclkStart && pllEnable;
    endsequence

    property p_mclk_aligned;
        @(posedge ref_clk) disable iff (!rst_n) s_bclk_start |=> (mclk && bclkRegen);
    endproperty

    AST_MCLK_PHASE_LOCK: assert property (p_mclk_aligned)
        else $error("master clock not aligned to bit clock rise");

    AST_RATIO_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !bclkStart |=> $stable(mHalf))
        else $error("master clock ratio changed mid period");
endmodule : dao_mclk_gen
`default_nettype wire

//--- logic/dao_audio_out.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Drive bit clock, word clock, data, master clock
// - Audio taken from frame or blanking stream
// - Cleaned bit clock regenerated from averaged period
// - Secondary data in 18-bit mode, same bit clock
// - Secondary enabled by strap or register bit
// - Master clock at x1, x2 or x4
// - Master clock off while cleaning disabled
// - Default master clock ratio is x2
// - Override bit first, then ratio code
// - Low bit clock band: codes 000..010
// - High bit clock band: codes 011..101
// - Channel B strap forces 18-bit mode
module dao_audio_out #(
    parameter int PERIOD_W = 10
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       frameBitClk,
    input  wire logic       frameWordClk,
    input  wire logic       frameDataA,
    input  wire logic       frameDataB,
    input  wire logic       blankBitClk,
    input  wire logic       blankWordClk,
    input  wire logic       blankDataA,
    input  wire logic       blankDataB,
    input  wire logic       modeSelChanB,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic            audioBitClk,
    output logic            audioWordClock,
    output logic            audioPrimaryData,
    output logic            audioSecondaryData,
    output logic            masterClk,
    output logic            videoMode18,
    output logic [7:0]      regRdData
);
    localparam int NSYNC = 9;

    logic [NSYNC-1:0]    pinIn;
    logic [NSYNC-1:0]    sync1;
    logic [NSYNC-1:0]    sync2;
    logic [NSYNC-1:0]    sync3;
    logic [NSYNC-1:0]    pinFilt;
    logic [3:0]          selVec;
    logic [7:0]          ctrl;
    logic                ratioOvr;
    logic [2:0]          ratioCode;
    logic [1:0]          ratioShift;
    logic [1:0]          band;
    logic                pllEn;
    logic                blankSel;
    logic                secEnable;
    logic                strapChanB;
    logic [2:0]          strapCnt;
    logic                prevBclk;
    logic                bitRise;
    logic                capWord;
    logic                capA;
    logic                capB;
    logic                next_outBclk;
    logic                outFall;
    logic                regenBclk;
    logic                regenMclk;
    logic                pllLocked;
    logic [PERIOD_W-1:0] period;

    if (PERIOD_W < 8) begin : g_bad_width
        $error("dao_audio_out: PERIOD_W too small");
    end

    // Code base of the bit clock band; longer period means lower base
    function automatic logic [1:0] band_of(input logic [PERIOD_W-1:0] p);
        if (p >= PERIOD_W'(dao_pkg::BAND1_CYC)) begin
            band_of = 2'h0;
        end else if (p >= PERIOD_W'(dao_pkg::BAND2_CYC)) begin
            band_of = 2'h1;
        end else if (p >= PERIOD_W'(dao_pkg::BAND3_CYC)) begin
            band_of = 2'h2;
        end else begin
            band_of = 2'h3;
        end
    endfunction : band_of

    assign pinIn = {modeSelChanB, blankDataB, blankDataA, blankWordClk, blankBitClk,
                    frameDataB, frameDataA, frameWordClk, frameBitClk};

    // Three-stage pin synchroniser, a change counts once stages two and three agree
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                sync1[i]   <= 1'b0;
                sync2[i]   <= 1'b0;
                sync3[i]   <= 1'b0;
                pinFilt[i] <= 1'b0;
            end else begin
                sync1[i] <= pinIn[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i]) begin
                    pinFilt[i] <= sync3[i];
                end
            end
        end
    end

    assign pllEn     = ctrl[dao_pkg::CTRL_PLL_EN_BIT];
    assign blankSel  = ctrl[dao_pkg::CTRL_BLANK_SRC_BIT];
    assign secEnable = strapChanB | ctrl[dao_pkg::CTRL_SEC_EN_BIT];
    assign selVec    = blankSel ? pinFilt[7:4] : pinFilt[3:0];
    assign bitRise   = selVec[0] & ~prevBclk;
    assign band      = band_of(period);

    always_comb begin
        if (!ratioOvr) begin
            ratioShift = dao_pkg::SHIFT_DEFAULT;
        end else if (ratioCode <= {1'b0, band}) begin
            ratioShift = 2'h0;
        end else if (ratioCode - {1'b0, band} >= {1'b0, dao_pkg::SHIFT_MAX}) begin
            ratioShift = dao_pkg::SHIFT_MAX;
        end else begin
            ratioShift = 2'(ratioCode - {1'b0, band});
        end
    end

    // Strap caught a few cycles after release, once the synchroniser settled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strapCnt   <= 3'h0;
            strapChanB <= 1'b0;
        end else if (strapCnt != 3'(dao_pkg::STRAP_WAIT_CYC)) begin
            strapCnt <= strapCnt + 3'h1;
            if (strapCnt == 3'(dao_pkg::STRAP_WAIT_CYC - 1)) begin
                strapChanB <= pinFilt[8];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl      <= dao_pkg::CTRL_RESET;
            ratioOvr  <= 1'b0;
            ratioCode <= dao_pkg::MSEL_CODE_RST;
        end else if (regWrEn) begin
            if (regAddr == dao_pkg::ADDR_AUDIO_CTRL) begin
                ctrl <= regWrData;
            end
            if (regAddr == dao_pkg::ADDR_MCLK_SEL) begin
                ratioOvr <= regWrData[dao_pkg::MSEL_OVR_BIT];
                if (ratioOvr) begin
                    ratioCode <= regWrData[dao_pkg::MSEL_CODE_LSB +: 3];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                dao_pkg::ADDR_AUDIO_CTRL: regRdData <= ctrl;
                dao_pkg::ADDR_MCLK_SEL:   regRdData <= {ratioOvr, ratioCode, pllLocked, 1'b0, band};
                default:                  regRdData <= 8'h00;
            endcase
        end
    end

    dao_mclk_gen #(
        .PERIOD_W (PERIOD_W)
    ) u_mclk_gen (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .bitRise    (bitRise),
        .pllEnable  (pllEn),
        .ratioShift (ratioShift),
        .bclkRegen  (regenBclk),
        .mclk       (regenMclk),
        .locked     (pllLocked),
        .period     (period)
    );

    // Samples taken on the recovered rise, relaunched on the output fall
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevBclk <= 1'b0;
            capWord  <= 1'b0;
            capA     <= 1'b0;
            capB     <= 1'b0;
        end else begin
            prevBclk <= selVec[0];
            if (bitRise) begin
                capWord <= selVec[1];
                capA    <= selVec[2];
                capB    <= selVec[3];
            end
        end
    end

    assign next_outBclk = pllEn ? regenBclk : selVec[0];
    assign outFall      = audioBitClk & ~next_outBclk;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            audioBitClk        <= 1'b0;
            audioWordClock     <= 1'b0;
            audioPrimaryData   <= 1'b0;
            audioSecondaryData <= 1'b0;
            masterClk          <= 1'b0;
            videoMode18        <= 1'b0;
        end else begin
            audioBitClk <= next_outBclk;
            masterClk   <= regenMclk & pllEn;
            videoMode18 <= secEnable;
            if (outFall) begin
                audioWordClock   <= capWord;
                audioPrimaryData <= capA;
            end
            if (!secEnable) begin
                audioSecondaryData <= 1'b0;
            end else if (outFall) begin
                audioSecondaryData <= capB;
            end
        end
    end

    AST_MCLK_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pllEn |=> !masterClk)
        else $error("master clock running with cleaning disabled");

    AST_SEC_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !secEnable |=> !audioSecondaryData)
        else $error("secondary data driven while disabled");

    AST_MODE18: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strapChanB ##1 strapChanB |-> videoMode18)
        else $error("strap channel B did not select 18-bit mode");

    AST_DEFAULT_X2: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ratioOvr |-> (ratioShift == dao_pkg::SHIFT_DEFAULT))
        else $error("default master clock ratio not x2");

    AST_CODE_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regWrEn && regAddr == dao_pkg::ADDR_MCLK_SEL && !ratioOvr) |=> $stable(ratioCode))
        else $error("ratio code taken without override bit");

    AST_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!pllEn && !$past(pllEn)) |=> (audioBitClk == $past(selVec[0])))
        else $error("bit clock not passed through with cleaning off");

    AST_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bitRise && blankSel) |=> (capA == $past(pinFilt[6])))
        else $error("blanking source not used");

    AST_SHIFT_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ratioShift <= dao_pkg::SHIFT_MAX)
        else $error("master clock ratio beyond x4");
endmodule : dao_audio_out
`default_nettype wire

//--- bench/dao_audio_sink.sv
`timescale 1ns/1ps
`default_nettype none
module dao_audio_sink (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        bitClk,
    input  wire logic        wordClk,
    input  wire logic        dataA,
    input  wire logic        dataB,
    input  wire logic        mclk,
    output logic [15:0]      shA,
    output logic [15:0]      shB,
    output logic [15:0]      shW,
    output logic [7:0]       perBit,
    output logic [15:0]      mclkRises
);
    logic       bitQ;
    logic       mclkQ;
    logic [7:0] cnt;
    logic       bRise;
    logic       mRise;
    assign bRise = bitClk & ~bitQ;
    assign mRise = mclk & ~mclkQ;
    // Capture on bit clock rise, as a codec would
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitQ <= 1'b0;
            shA  <= 16'h0000;
            shB  <= 16'h0000;
            shW  <= 16'h0000;
        end else begin
            bitQ <= bitClk;
            if (bRise) begin
                shA <= {shA[14:0], dataA};
                shB <= {shB[14:0], dataB};
                shW <= {shW[14:0], wordClk};
            end
        end
    end
    // Master clock rises counted per bit period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mclkQ     <= 1'b0;
            cnt       <= 8'h00;
            perBit    <= 8'h00;
            mclkRises <= 16'h0000;
        end else begin
            mclkQ     <= mclk;
            mclkRises <= mclkRises + {15'h0000, mRise};
            if (bRise) begin
                perBit <= cnt;
                cnt    <= {7'h00, mRise};
            end else begin
                cnt <= cnt + {7'h00, mRise};
            end
        end
    end
endmodule : dao_audio_sink
`default_nettype wire

//--- bench/dao_audio_out_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dao_audio_out_tb_top;
    localparam logic [15:0] PAT_FA = 16'h0f35;
    localparam logic [15:0] PAT_FB = 16'h6e01;
    localparam logic [15:0] PAT_BA = 16'h3a0b;
    localparam logic [15:0] PAT_BB = 16'h1c7d;
    localparam logic [15:0] PAT_W  = 16'h00ff;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        bclk = 1'b0;
    logic        wclk = 1'b0;
    logic        frA  = 1'b0;
    logic        frB  = 1'b0;
    logic        blA  = 1'b0;
    logic        blB  = 1'b0;
    logic        chanB  = 1'b0;
    logic        wrEn   = 1'b0;
    logic        rdEn   = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [7:0]  wrData = 8'h00;
    logic        oBit, oWord, oA, oB, oM, mode18;
    logic [7:0]  rdData;
    logic [15:0] shA, shB, shW, mclkRises;
    logic [7:0]  perBit;
    int          halfCyc = 5;
    int          linkCnt = 0;
    int          bitIdx  = 15;
    int          cycles  = 0;
    int          err_count = 0;
    int          checks    = 0;

    always #4 ref_clk = ~ref_clk;

    // Link source; 80 ns bit clock, slower ones only for ratio bands, all above 1 MHz
    always @(negedge ref_clk) begin
        if (linkCnt >= halfCyc - 1) begin
            linkCnt <= 0;
            bclk    <= ~bclk;
            if (bclk) begin
                frA    <= PAT_FA[bitIdx];
                frB    <= PAT_FB[bitIdx];
                blA    <= PAT_BA[bitIdx];
                blB    <= PAT_BB[bitIdx];
                wclk   <= PAT_W[bitIdx];
                bitIdx <= (bitIdx + 15) % 16;
            end
        end else begin
            linkCnt <= linkCnt + 1;
        end
    end

    dao_audio_out #(.PERIOD_W(10)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .frameBitClk(bclk), .frameWordClk(wclk), .frameDataA(frA), .frameDataB(frB),
        .blankBitClk(bclk), .blankWordClk(wclk), .blankDataA(blA), .blankDataB(blB),
        .modeSelChanB(chanB), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr),
        .regWrData(wrData), .audioBitClk(oBit), .audioWordClock(oWord),
        .audioPrimaryData(oA), .audioSecondaryData(oB), .masterClk(oM),
        .videoMode18(mode18), .regRdData(rdData)
    );

    dao_audio_sink sink_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .bitClk(oBit), .wordClk(oWord), .dataA(oA),
        .dataB(oB), .mclk(oM), .shA(shA), .shB(shB), .shW(shW), .perBit(perBit),
        .mclkRises(mclkRises)
    );

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic checkVal(string name, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : checkVal

    // Stream phase is free, so accept any rotation of the pattern
    function automatic logic [15:0] rotFit(logic [15:0] pat, logic [15:0] got);
        logic [15:0] r;
        r = pat;
        for (int i = 0; i < 16; i++) begin
            if (r === got) return got;
            r = {r[14:0], r[15]};
        end
        return pat;
    endfunction : rotFit

    task automatic regWrite(logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk);
        wrEn   = 1'b1;
        addr   = a;
        wrData = d;
        @(negedge ref_clk);
        wrEn = 1'b0;
    endtask : regWrite

    task automatic regRead(logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        rdEn = 1'b1;
        addr = a;
        @(negedge ref_clk);
        rdEn = 1'b0;
        @(negedge ref_clk);
        d = rdData;
    endtask : regRead

    task automatic settle(int bits);
        repeat (bits * 2 * halfCyc) @(negedge ref_clk);
    endtask : settle

    task automatic waitLock();
        logic [7:0] d = 8'h00;
        int         n = 0;
        settle(6);
        while (d[3] !== 1'b1 && n < 4000) begin
            regRead(dao_pkg::ADDR_MCLK_SEL, d);
            n++;
        end
        checkVal("pll lock", 16'h0001, {15'h0000, d[3]});
        settle(8);
    endtask : waitLock

    // Strap is only taken after a reset, so a mid-run reset applies it
    task automatic pulseReset();
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
    endtask : pulseReset

    task automatic testRegs();
        logic [7:0] d;
        regRead(dao_pkg::ADDR_AUDIO_CTRL, d);
        checkVal("ctrl reset", {8'h00, dao_pkg::CTRL_RESET}, {8'h00, d});
        regRead(dao_pkg::ADDR_MCLK_SEL, d);
        checkVal("ratio reset", 16'h0000, {12'h000, d[7:4]});
        regWrite(8'h55, 8'hff);
        regRead(8'h55, d);
        checkVal("unmapped", 16'h0000, {8'h00, d});
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'he1);
        regRead(dao_pkg::ADDR_AUDIO_CTRL, d);
        checkVal("ctrl readback", 16'h00e1, {8'h00, d});
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'h01);
        $display("test regs done");
    endtask : testRegs

    task automatic testData();
        settle(40);
        checkVal("primary", rotFit(PAT_FA, shA), shA);
        checkVal("word clock", rotFit(PAT_W, shW), shW);
        checkVal("secondary off", 16'h0000, shB);
        checkVal("mode18 off", 16'h0000, {15'h0000, mode18});
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'h05);
        settle(40);
        checkVal("secondary reg", rotFit(PAT_FB, shB), shB);
        checkVal("mode18 reg", 16'h0001, {15'h0000, mode18});
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'h07);
        settle(40);
        checkVal("blank primary", rotFit(PAT_BA, shA), shA);
        checkVal("blank secondary", rotFit(PAT_BB, shB), shB);
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'h01);
        @(negedge ref_clk);
        chanB = 1'b1;
        pulseReset();
        settle(40);
        checkVal("mode18 strap", 16'h0001, {15'h0000, mode18});
        checkVal("secondary strap", rotFit(PAT_FB, shB), shB);
        @(negedge ref_clk);
        chanB = 1'b0;
        pulseReset();
        settle(10);
        checkVal("mode18 clear", 16'h0000, {15'h0000, mode18});
        $display("test data done");
    endtask : testData

    task automatic testPllOff();
        logic [15:0] m;
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'h00);
        settle(10);
        m = mclkRises;
        settle(40);
        checkVal("mclk rises off", m, mclkRises);
        checkVal("mclk level off", 16'h0000, {15'h0000, oM});
        checkVal("primary pll off", rotFit(PAT_FA, shA), shA);
        regWrite(dao_pkg::ADDR_AUDIO_CTRL, 8'h01);
        $display("test pll off done");
    endtask : testPllOff

    task automatic testOrder();
        logic [7:0] d;
        @(posedge ref_clk);
        halfCyc = 16;
        waitLock();
        checkVal("default ratio", 16'h0002, {8'h00, perBit});
        regWrite(dao_pkg::ADDR_MCLK_SEL, 8'hb0);
        regRead(dao_pkg::ADDR_MCLK_SEL, d);
        checkVal("code before override", 16'h0008, {12'h000, d[7:4]});
        waitLock();
        // Override on with code 000 clamps to x1 in this band
        checkVal("ratio override", 16'h0001, {8'h00, perBit});
        regWrite(dao_pkg::ADDR_MCLK_SEL, 8'hb0);
        regRead(dao_pkg::ADDR_MCLK_SEL, d);
        checkVal("code after override", 16'h000b, {12'h000, d[7:4]});
        checkVal("band", 16'h0002, {14'h0000, d[1:0]});
        $display("test order done");
    endtask : testOrder

    task automatic testRatio();
        int         hc[7] = '{60, 60, 60, 16, 16, 16, 5};
        logic [2:0] cd[7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h3};
        logic [7:0] ex[7] = '{8'h01, 8'h02, 8'h04, 8'h01, 8'h02, 8'h04, 8'h01};
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            halfCyc = hc[i];
            regWrite(dao_pkg::ADDR_MCLK_SEL, {1'b1, cd[i], 4'h0});
            waitLock();
            checkVal("mclk per bit", {8'h00, ex[i]}, {8'h00, perBit});
        end
        $display("test ratio done");
    endtask : testRatio

    initial begin
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        testRegs();
        testData();
        testPllOff();
        testOrder();
        testRatio();
        print_verdict();
    end
endmodule : dao_audio_out_tb_top
`default_nettype wire
